// ### hw/clock_block.sv
`timescale 1ns/100ps
`default_nettype none
module clock_block (
  input  wire logic                        mclk,
  input  wire logic                        sys_rst,
  input  wire logic                        cfg_we,
  input  wire logic                        cfg_src,
  input  wire logic [port_pkg::DIV_W-1:0]  cfg_div,
  input  wire logic                        pin_edge,
  output logic                             tick
);
  logic                       src_q;
  logic [port_pkg::DIV_W-1:0] div_q;
  logic [port_pkg::DIV_W-1:0] cnt_q;
  logic                       src_evt;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      src_q <= 1'b0;
      div_q <= port_pkg::DIV_RST;
    end else if (cfg_we) begin
      src_q <= cfg_src;
      div_q <= cfg_div;
    end
  end

  // External clock or reference pacing
  assign src_evt = src_q ? pin_edge : 1'b1; // RULE_14

  always_ff @(posedge mclk) begin
    if (sys_rst || cfg_we) begin
      cnt_q <= port_pkg::DIV_RST;
    end else if (src_evt) begin
      cnt_q <= (cnt_q >= div_q) ? port_pkg::DIV_RST : cnt_q + 16'h0001;
    end
  end

  // Divide by div+1; zero passes the source straight through
  assign tick = src_evt && (cnt_q >= div_q); // RULE_15
endmodule : clock_block
`default_nettype wire

// ### hw/port_pkg.sv
package port_pkg;
  localparam int unsigned DW          = 32;
  localparam int unsigned AW          = 8;
  localparam int unsigned CNT_W       = 16;
  localparam int unsigned NUM_CLKBLK  = 6;
  localparam int unsigned CB_W        = 3;
  localparam int unsigned DIV_W       = 16;
  localparam int unsigned REM_W       = 6;
  localparam int unsigned PAD_W       = 6;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_DATA     = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_COUNT    = 8'h0c;
  localparam logic [7:0] OFS_TIME     = 8'h10;
  localparam logic [7:0] OFS_TSTAMP   = 8'h14;
  localparam logic [7:0] OFS_COND     = 8'h18;
  localparam logic [7:0] OFS_CLKCFG   = 8'h1c;
  // Control field positions
  localparam int unsigned CTL_EN      = 0;
  localparam int unsigned CTL_DIR     = 1;
  localparam int unsigned CTL_OD      = 2;
  localparam int unsigned CTL_WID     = 3;
  localparam int unsigned CTL_CB      = 6;
  localparam int unsigned CTL_STBI    = 9;
  localparam int unsigned CTL_STBO    = 10;
  localparam int unsigned CTL_COND    = 12;
  localparam int unsigned CTL_PAD     = 14;
  localparam int unsigned CTL_USED    = 20;
  // Clock block config field positions
  localparam int unsigned CBC_IDX     = 0;
  localparam int unsigned CBC_SRC     = 3;
  localparam int unsigned CBC_DIV     = 4;
  // Reset values
  localparam logic [19:0] CTRL_RST    = 20'h00000;
  localparam logic [2:0]  CB_RST      = 3'h0;
  localparam logic [15:0] DIV_RST     = 16'h0000;
  localparam logic [15:0] CNT_RST     = 16'h0000;
  // Width select codes
  localparam logic [2:0] WID_1        = 3'h0;
  localparam logic [2:0] WID_4        = 3'h1;
  localparam logic [2:0] WID_8        = 3'h2;
  localparam logic [2:0] WID_16       = 3'h3;
  localparam logic [2:0] WID_32       = 3'h4;
  // Condition codes
  localparam logic [1:0] COND_NONE    = 2'h0;
  localparam logic [1:0] COND_EQ      = 2'h1;
  localparam logic [1:0] COND_NEQ     = 2'h2;
  // Reference clock block runs at the system clock rate
  localparam int unsigned REF_MHZ     = 100;
  localparam int unsigned MCLK_MHZ    = 100;
  localparam int unsigned REF_DIV     = MCLK_MHZ / REF_MHZ;
endpackage : port_pkg

// ### hw/timed_port.sv
// Function
// RULE_01: Port widths 1,4,8,16,32; all pins of a port share one direction.
// RULE_02: Port drives pins or samples them, optionally waiting on a condition.
// RULE_03: Every port access completes in one cycle, never waits.
// RULE_04: Open-drain: zero pulls low, one leaves pin undriven; per port.
// RULE_05: Data passes through a shift register and a transfer register.
// RULE_06: A 16-bit counter can time transfers between pins and transfer reg.
// RULE_07: Counter readable anytime; transfers can wait for a future count.
// RULE_08: Each transfer captures the counter as a readable timestamp.
// RULE_09: An enabled link disables the port pins it shares.
// RULE_10: A narrower enabled port owns pins shared with this wider port.
// RULE_11: Pins not taken by a narrower port stay usable by this port.
// RULE_12: Port always transfers at its nominal width.
// RULE_13: Six clock blocks; block 0 is the 100MHz reference by default.
// RULE_14: A clock block may take a 1-bit pin as its clock source.
// RULE_15: A pin-sourced clock block may divide its incoming clock.
// RULE_16: Port honours an input strobe and drives an output strobe.
// RULE_17: After reset the port uses clock block 0.
// RULE_18: Pin events go straight to the scheduler, not as interrupts.
// RULE_19: Six pad control bits are set per port.
// RULE_20: Counter steps once per selected clock tick, wrapping at 65536.
`timescale 1ns/100ps
`default_nettype none
module timed_port (
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_we,
  input  wire logic                 reg_re,
  output logic      [31:0]          reg_rdata,
  input  wire logic [31:0]          pin_in,
  output logic      [31:0]          pin_out,
  output logic      [31:0]          pin_oe,
  input  wire logic                 clk_pin,
  input  wire logic                 strobe_input,
  output logic                      strobe_output,
  input  wire logic [31:0]          link_take,
  input  wire logic [31:0]          narrow_take,
  output logic      [5:0]           pad_ctrl,
  output logic                      sched_event
);
  logic [19:0] ctrl_q;
  logic [31:0] tr_q;
  logic        tr_full_q;
  logic [31:0] sh_q;
  logic [5:0]  rem_q;
  logic [15:0] cnt_q;
  logic [15:0] time_q;
  logic        timed_q;
  logic [15:0] tstamp_q;
  logic [31:0] cond_q;
  logic [31:0] out_q;
  logic        stbo_q;
  logic        evt_q;
  logic [31:0] rdata_q;
  logic [31:0] pin_s1_q;
  logic [31:0] pin_s2_q;
  logic [2:0]  cks_q;
  logic        stbi_s1_q;
  logic        stbi_s2_q;
  logic [5:0]  ticks;
  logic        tick;
  logic        pin_edge;
  logic        cfg_hit;
  logic [5:0]  cfg_we;
  logic        en;
  logic        dir_out;
  logic [2:0]  wid;
  logic [31:0] wmask;
  logic [5:0]  nslice;
  logic        go_time;
  logic        go_cond;
  logic        go_stb;
  logic        data_rd;
  logic        data_wr;
  logic        dir_chg;

  // Field views of the control word
  assign en      = ctrl_q[port_pkg::CTL_EN];
  assign dir_out = ctrl_q[port_pkg::CTL_DIR]; // RULE_01
  assign wid     = ctrl_q[port_pkg::CTL_WID +: 3];
  assign pad_ctrl = ctrl_q[port_pkg::CTL_PAD +: port_pkg::PAD_W]; // RULE_19

  function automatic logic [31:0] width_mask(input logic [2:0] w);
    case (w)
      port_pkg::WID_1:  width_mask = 32'h00000001;
      port_pkg::WID_4:  width_mask = 32'h0000000f;
      port_pkg::WID_8:  width_mask = 32'h000000ff;
      port_pkg::WID_16: width_mask = 32'h0000ffff;
      default:          width_mask = 32'hffffffff;
    endcase
  endfunction : width_mask

  function automatic logic [5:0] slices(input logic [2:0] w);
    case (w)
      port_pkg::WID_1:  slices = 6'h20;
      port_pkg::WID_4:  slices = 6'h08;
      port_pkg::WID_8:  slices = 6'h04;
      port_pkg::WID_16: slices = 6'h02;
      default:          slices = 6'h01;
    endcase
  endfunction : slices

  function automatic logic [31:0] shift_out(input logic [31:0] v,
                                            input logic [2:0]  w);
    case (w)
      port_pkg::WID_1:  shift_out = {1'b0, v[31:1]};
      port_pkg::WID_4:  shift_out = {4'h0, v[31:4]};
      port_pkg::WID_8:  shift_out = {8'h00, v[31:8]};
      port_pkg::WID_16: shift_out = {16'h0000, v[31:16]};
      default:          shift_out = 32'h00000000;
    endcase
  endfunction : shift_out

  // New slice enters at the top so the first sample ends lowest
  function automatic logic [31:0] shift_in(input logic [31:0] v,
                                           input logic [31:0] p,
                                           input logic [2:0]  w);
    case (w)
      port_pkg::WID_1:  shift_in = {p[0], v[31:1]};
      port_pkg::WID_4:  shift_in = {p[3:0], v[31:4]};
      port_pkg::WID_8:  shift_in = {p[7:0], v[31:8]};
      port_pkg::WID_16: shift_in = {p[15:0], v[31:16]};
      default:          shift_in = p;
    endcase
  endfunction : shift_in

  assign wmask  = width_mask(wid);
  assign nslice = slices(wid); // RULE_12

  // Pins from outside pass two flops before use
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_s1_q  <= 32'h00000000;
      pin_s2_q  <= 32'h00000000;
      stbi_s1_q <= 1'b0;
      stbi_s2_q <= 1'b0;
    end else begin
      pin_s1_q  <= pin_in;
      pin_s2_q  <= pin_s1_q;
      stbi_s1_q <= strobe_input;
      stbi_s2_q <= stbi_s1_q;
    end
  end

  // External clock pin: sync then rising edge
  logic ck_s1_q;
  logic ck_s2_q;
  logic ck_s3_q;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      ck_s3_q <= 1'b0;
    end else begin
      ck_s1_q <= clk_pin;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
    end
  end
  assign pin_edge = ck_s2_q && !ck_s3_q; // RULE_14

  // Block 0 is the reference: one tick per system cycle
  assign ticks[0] = 1'b1; // RULE_13
  assign cfg_hit  = reg_we && (reg_addr == port_pkg::OFS_CLKCFG);

  genvar g;
  generate
    for (g = 1; g < port_pkg::NUM_CLKBLK; g++) begin : g_cb
      assign cfg_we[g] = cfg_hit &&
        (reg_wdata[port_pkg::CBC_IDX +: 3] == 3'(g));
      clock_block u_cb (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .cfg_we   (cfg_we[g]),
        .cfg_src  (reg_wdata[port_pkg::CBC_SRC]),
        .cfg_div  (reg_wdata[port_pkg::CBC_DIV +: port_pkg::DIV_W]),
        .pin_edge (pin_edge),
        .tick     (ticks[g])
      ); // RULE_13
    end
  endgenerate
  assign cfg_we[0] = 1'b0;

  // Out-of-range block index falls back to the reference
  assign tick = (cks_q < 3'(port_pkg::NUM_CLKBLK)) ? ticks[cks_q] : ticks[0];

  // Control and configuration
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_q <= port_pkg::CTRL_RST;
      cks_q  <= port_pkg::CB_RST; // RULE_17
    end else if (reg_we && reg_addr == port_pkg::OFS_CTRL) begin
      ctrl_q <= reg_wdata[19:0];
      cks_q  <= reg_wdata[port_pkg::CTL_CB +: port_pkg::CB_W];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cond_q <= 32'h00000000;
    end else if (reg_we && reg_addr == port_pkg::OFS_COND) begin
      cond_q <= reg_wdata;
    end
  end

  // Port counter
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_q <= port_pkg::CNT_RST;
    end else if (tick) begin
      cnt_q <= cnt_q + 16'h0001; // RULE_20
    end
  end

  // Transfer gating terms
  assign go_time = !timed_q || (cnt_q == time_q); // RULE_07
  assign go_stb  = !ctrl_q[port_pkg::CTL_STBI] || stbi_s2_q; // RULE_16
  always_comb begin
    case (ctrl_q[port_pkg::CTL_COND +: 2])
      port_pkg::COND_EQ:  go_cond = ((pin_s2_q ^ cond_q) & wmask) == 32'h0;
      port_pkg::COND_NEQ: go_cond = ((pin_s2_q ^ cond_q) & wmask) != 32'h0;
      default:            go_cond = 1'b1;
    endcase
  end // RULE_02

  assign data_wr = reg_we && reg_addr == port_pkg::OFS_DATA;
  assign data_rd = reg_re && reg_addr == port_pkg::OFS_DATA;
  assign dir_chg = reg_we && reg_addr == port_pkg::OFS_CTRL &&
                   (reg_wdata[port_pkg::CTL_DIR] != dir_out);

  // Timed transfer arm: one shot, used by the next word start
  logic start;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      time_q  <= 16'h0000;
      timed_q <= 1'b0;
    end else if (reg_we && reg_addr == port_pkg::OFS_TIME) begin
      time_q  <= reg_wdata[15:0];
      timed_q <= 1'b1; // RULE_06
    end else if (start) begin
      timed_q <= 1'b0;
    end
  end

  // Start of a word: output needs a full transfer reg, input needs its condition and strobe
  assign start = en && tick && (rem_q == 6'h00) && go_time &&
                 (dir_out ? tr_full_q : (go_cond && go_stb)); // RULE_06

  // Serializer / deserializer and transfer register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sh_q      <= 32'h00000000;
      rem_q     <= 6'h00;
      tr_q      <= 32'h00000000;
      tr_full_q <= 1'b0;
      out_q     <= 32'h00000000;
      stbo_q    <= 1'b0;
      evt_q     <= 1'b0;
      tstamp_q  <= 16'h0000;
    end else begin
      stbo_q <= 1'b0;
      evt_q  <= 1'b0;
      if (dir_out) begin
        if (data_wr) begin
          tr_q      <= reg_wdata;
          tr_full_q <= 1'b1;
        end
        if (start) begin
          out_q     <= tr_q;
          sh_q      <= shift_out(tr_q, wid);
          rem_q     <= nslice - 6'h01;
          tr_full_q <= data_wr; // RULE_05
          tstamp_q  <= cnt_q; // RULE_08
          stbo_q    <= ctrl_q[port_pkg::CTL_STBO]; // RULE_16
          evt_q     <= 1'b1;
        end else if (en && tick && rem_q != 6'h00) begin
          out_q  <= sh_q;
          sh_q   <= shift_out(sh_q, wid);
          rem_q  <= rem_q - 6'h01;
          stbo_q <= ctrl_q[port_pkg::CTL_STBO];
        end
      end else begin
        // New data wins over a read clearing the full flag
        if (data_rd) begin
          tr_full_q <= 1'b0;
        end
        if (en && tick && go_stb && (start || rem_q != 6'h00)) begin
          if (start) begin
            tstamp_q <= cnt_q; // RULE_08
          end
          if (rem_q + 6'h01 == nslice) begin
            tr_q      <= shift_in(sh_q, pin_s2_q, wid); // RULE_05
            tr_full_q <= 1'b1;
            rem_q     <= 6'h00;
            evt_q     <= 1'b1;
          end else begin
            sh_q  <= shift_in(sh_q, pin_s2_q, wid);
            rem_q <= rem_q + 6'h01;
          end
        end
      end
      // Turning the port round drops a half-moved word, so a captured
      // input word is never sent back out as output data
      if (dir_chg) begin
        rem_q     <= 6'h00;
        tr_full_q <= 1'b0;
      end
    end
  end
  // Overrun: an input word landing on a full register replaces it

  // Scheduler wake, no interrupt path
  assign sched_event = evt_q; // RULE_18
  assign strobe_output = stbo_q;

  // Pin ownership and drive
  logic [31:0] own;
  assign own = wmask & ~link_take /* RULE_09 */ & ~narrow_take; // RULE_10
  // Untaken pins of this port still drive normally
  always_comb begin
    pin_out = out_q & own; // RULE_11
    if (en && dir_out) begin
      if (ctrl_q[port_pkg::CTL_OD]) begin
        pin_oe = ~out_q & own; // RULE_04
      end else begin
        pin_oe = own; // RULE_02
      end
    end else begin
      pin_oe = 32'h00000000;
    end
  end

  // Register reads: data the cycle after the strobe, no wait states
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_q <= 32'h00000000;
    end else if (reg_re) begin
      case (reg_addr)
        port_pkg::OFS_CTRL:   rdata_q <= {12'h000, ctrl_q};
        port_pkg::OFS_DATA:   rdata_q <= tr_q;
        port_pkg::OFS_STATUS: rdata_q <= {29'h0, timed_q,
                                          rem_q != 6'h00, tr_full_q};
        port_pkg::OFS_COUNT:  rdata_q <= {16'h0000, cnt_q}; // RULE_07
        port_pkg::OFS_TIME:   rdata_q <= {16'h0000, time_q};
        port_pkg::OFS_TSTAMP: rdata_q <= {16'h0000, tstamp_q}; // RULE_08
        port_pkg::OFS_COND:   rdata_q <= cond_q;
        default:              rdata_q <= 32'h00000000;
      endcase
    end else begin
      rdata_q <= 32'h00000000;
    end
  end
  assign reg_rdata = rdata_q; // RULE_03
endmodule : timed_port
`default_nettype wire

// ### tb/pin_partner.sv
`timescale 1ns/100ps
`default_nettype none
module pin_partner #(
  parameter int HALF_NS = 23
) (
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] ext_drv,
  input  wire logic [31:0] ext_oe,
  input  wire logic        stb_req,
  input  wire logic        clk_run,
  output logic      [31:0] pin_in,
  output logic             clk_pin,
  output logic             strobe_input
);
  // Pull-ups: a released line reads 1, never the last value
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_drv)
                | (~pin_oe & ~ext_oe);
  assign strobe_input = stb_req;
  // Clock stands low between bursts
  initial clk_pin = 1'b0;
  always begin
    wait (clk_run);
    #(HALF_NS) clk_pin = 1'b1;
    #(HALF_NS) clk_pin = 1'b0;
  end
endmodule : pin_partner
`default_nettype wire

// ### tb/timed_port_checker.sv
`timescale 1ns/100ps
`default_nettype none
module timed_port_checker (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_we,
  input wire logic        reg_re,
  input wire logic [31:0] reg_rdata,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] link_take,
  input wire logic [31:0] narrow_take,
  input wire logic        strobe_output,
  input wire logic [5:0]  pad_ctrl
);
  default clocking dck @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  logic [19:0] ctrl_q;
  // Bus-side copy of the control word
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_q <= port_pkg::CTRL_RST;
    end else if (reg_we && reg_addr == port_pkg::OFS_CTRL) begin
      ctrl_q <= reg_wdata[19:0];
    end
  end
  // Block 0 always ticks every cycle, so with it selected the step is known
  sequence s_cnt_rd;
    reg_re && reg_addr == port_pkg::OFS_COUNT
      && ctrl_q[port_pkg::CTL_EN] && ctrl_q[8:6] == 3'h0;
  endsequence
  property p_cnt_step;
    s_cnt_rd ##2 s_cnt_rd |=> reg_rdata == $past(reg_rdata, 2) + 32'h2;
  endproperty
  a_cnt_step: assert property (p_cnt_step)
    else $error("counter step wrong");
  property p_link;
    (pin_oe & link_take) == 32'h0;
  endproperty
  a_link: assert property (p_link)
    else $error("link pin driven");
  property p_narrow;
    (pin_oe & narrow_take) == 32'h0;
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("narrow pin driven");
  property p_dir;
    !ctrl_q[port_pkg::CTL_DIR] |-> pin_oe == 32'h0;
  endproperty
  a_dir: assert property (p_dir)
    else $error("input port drives");
  property p_od;
    ctrl_q[port_pkg::CTL_OD] |-> (pin_oe & pin_out) == 32'h0;
  endproperty
  a_od: assert property (p_od)
    else $error("open drain drives high");
  property p_rd_idle;
    !$past(reg_re) |-> reg_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside slot");
  property p_stbo;
    strobe_output |-> ctrl_q[port_pkg::CTL_STBO] && ctrl_q[port_pkg::CTL_DIR];
  endproperty
  a_stbo: assert property (p_stbo)
    else $error("strobe without enable");
  property p_pad;
    reg_we && reg_addr == port_pkg::OFS_CTRL |=> pad_ctrl == ctrl_q[19:14];
  endproperty
  a_pad: assert property (p_pad)
    else $error("pad bits not applied");
endmodule : timed_port_checker
bind timed_port timed_port_checker timed_port_checker_i (.mclk(mclk),
  .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
  .pin_out(pin_out), .pin_oe(pin_oe), .link_take(link_take),
  .narrow_take(narrow_take), .strobe_output(strobe_output),
  .pad_ctrl(pad_ctrl));
`default_nettype wire

// ### tb/timed_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
module timed_port_tb;
  logic        mclk, sys_rst, reg_we, reg_re, clk_pin, stb_req, clk_run;
  logic        strobe_input, strobe_output, sched_event;
  logic [7:0]  reg_addr;
  logic [5:0]  pad_ctrl;
  logic [31:0] reg_wdata, reg_rdata, pin_in, pin_out, pin_oe;
  logic [31:0] link_take, narrow_take, ext_drv, ext_oe, a, b;
  int          n_mismatch = 0;
  int          checked = 0;
  timed_port timed_port_i (.mclk(mclk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .clk_pin(clk_pin),
    .strobe_input(strobe_input), .strobe_output(strobe_output),
    .link_take(link_take), .narrow_take(narrow_take),
    .pad_ctrl(pad_ctrl), .sched_event(sched_event));
  pin_partner pin_partner_i (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_drv(ext_drv), .ext_oe(ext_oe), .stb_req(stb_req),
    .clk_run(clk_run), .pin_in(pin_in), .clk_pin(clk_pin),
    .strobe_input(strobe_input));
  always #5 mclk = ~mclk;
  function automatic logic [31:0] ctl(input logic [3:0] f,
    input logic [2:0] w, input logic [2:0] c, input logic [1:0] cd);
    ctl = 32'h1 | (32'(f[0]) << port_pkg::CTL_DIR);
    ctl |= (32'(f[1]) << port_pkg::CTL_OD) | (32'(w) << port_pkg::CTL_WID);
    ctl |= (32'(c) << port_pkg::CTL_CB) | (32'(f[2]) << port_pkg::CTL_STBI);
    ctl |= (32'(f[3]) << port_pkg::CTL_STBO) | (32'(cd) << port_pkg::CTL_COND);
  endfunction : ctl
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge mclk);
    reg_we <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge mclk);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [31:0] v);
    @(posedge mclk);
    reg_re <= 1'b1;
    reg_addr <= ad;
    @(posedge mclk);
    reg_re <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic t_basic;
    chk("oe_reset", 32'h0, pin_oe);
    wr(port_pkg::OFS_CTRL, ctl(4'h0, port_pkg::WID_32, 3'h0, 2'h0));
    wr(8'h44, 32'hffff_ffff);
    rd(port_pkg::OFS_CTRL, a);
    chk("ctrl_kept", ctl(4'h0, port_pkg::WID_32, 3'h0, 2'h0), a);
    rd(8'h40, a);
    chk("unmapped", 32'h0, a);
    rd(port_pkg::OFS_COUNT, a);
    rd(port_pkg::OFS_COUNT, b);
    chk("count_step", 32'h2, b - a);
    $display("test basic done");
  endtask : t_basic
  task automatic t_widths;
    logic [2:0]  w [5];
    logic [31:0] mk [5];
    w = '{port_pkg::WID_1, port_pkg::WID_4, port_pkg::WID_8,
          port_pkg::WID_16, port_pkg::WID_32};
    mk = '{32'h1, 32'hf, 32'hff, 32'hffff, 32'hffff_ffff};
    for (int i = 0; i < 5; i++) begin
      wr(port_pkg::OFS_CTRL, ctl(4'h1, w[i], 3'h0, 2'h0));
      #1 chk("width_oe", mk[i], pin_oe);
    end
    $display("test widths done");
  endtask : t_widths
  task automatic t_output;
    @(posedge mclk);
    narrow_take <= 32'h8;
    link_take <= 32'h20;
    wr(port_pkg::OFS_CTRL, ctl(4'h9, port_pkg::WID_8, 3'h0, 2'h0)
       | (32'h2a << port_pkg::CTL_PAD));
    #1 chk("pad", 32'h2a, {26'h0, pad_ctrl});
    chk("shared_oe", 32'hd7, pin_oe);
    rd(port_pkg::OFS_COUNT, a);
    wr(port_pkg::OFS_DATA, 32'h4433_2211);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      #1 chk("slice", {24'h0, 8'(32'h4433_2211 >> 8 * i) & 8'hd7},
             {24'h0, pin_out[7:0]});
      chk("strobe_out", 32'h1, {31'h0, strobe_output});
      chk("event", {31'h0, i == 0}, {31'h0, sched_event});
    end
    rd(port_pkg::OFS_TSTAMP, b);
    chk("tstamp", a + 32'h3, b);
    narrow_take <= 32'h0;
    link_take <= 32'h0;
    $display("test output done");
  endtask : t_output
  task automatic t_od;
    wr(port_pkg::OFS_CTRL, ctl(4'h3, port_pkg::WID_4, 3'h0, 2'h0));
    wr(port_pkg::OFS_DATA, 32'ha5);
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk);
      #1 chk("od_oe", i ? 32'h5 : 32'ha, {28'h0, pin_oe[3:0]});
      chk("od_wire", i ? 32'ha : 32'h5, {28'h0, pin_in[3:0]});
    end
    repeat (8) @(posedge mclk);
    $display("test open drain done");
  endtask : t_od
  task automatic t_input;
    @(posedge mclk);
    ext_oe <= 32'hffff_ffff;
    ext_drv <= 32'h1234;
    stb_req <= 1'b1;
    wr(port_pkg::OFS_COND, 32'h5a5a);
    wr(port_pkg::OFS_CTRL,
       ctl(4'h4, port_pkg::WID_32, 3'h0, port_pkg::COND_EQ));
    repeat (8) @(posedge mclk);
    rd(port_pkg::OFS_STATUS, a);
    chk("full_cond", 32'h0, {31'h0, a[0]});
    ext_drv <= 32'h5a5a;
    stb_req <= 1'b0;
    repeat (8) @(posedge mclk);
    rd(port_pkg::OFS_STATUS, a);
    chk("full_strobe", 32'h0, {31'h0, a[0]});
    stb_req <= 1'b1;
    repeat (8) @(posedge mclk);
    rd(port_pkg::OFS_STATUS, a);
    chk("full_set", 32'h1, {31'h0, a[0]});
    rd(port_pkg::OFS_DATA, a);
    chk("in_word", 32'h5a5a, a);
    $display("test input done");
  endtask : t_input
  task automatic t_timed;
    int n;
    @(posedge mclk);
    ext_oe <= 32'h0;
    wr(port_pkg::OFS_CTRL, ctl(4'h1, port_pkg::WID_32, 3'h0, 2'h0));
    rd(port_pkg::OFS_COUNT, a);
    wr(port_pkg::OFS_TIME, {16'h0, a[15:0] + 16'd30});
    wr(port_pkg::OFS_DATA, 32'hcafe_0001);
    for (n = 0; n < 60 && sched_event !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    chk("timed_out", 32'hcafe_0001, pin_out);
    rd(port_pkg::OFS_TSTAMP, b);
    chk("timed_stamp", {16'h0, a[15:0] + 16'd30}, b);
    $display("test timed done");
  endtask : t_timed
  task automatic t_clk;
    wr(port_pkg::OFS_CLKCFG, 32'h19);
    wr(port_pkg::OFS_CTRL, ctl(4'h0, port_pkg::WID_32, 3'h1, 2'h0));
    repeat (6) @(posedge mclk);
    rd(port_pkg::OFS_COUNT, a);
    clk_run = 1'b1;
    repeat (8) @(posedge clk_pin);
    clk_run = 1'b0;
    repeat (10) @(posedge mclk);
    rd(port_pkg::OFS_COUNT, b);
    chk("pin_clock", 32'h4, b - a);
    $display("test pin clock done");
  endtask : t_clk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    {mclk, reg_we, reg_re, stb_req, clk_run} = '0;
    {reg_addr, reg_wdata, link_take, narrow_take, ext_drv, ext_oe} = '0;
    sys_rst = 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    t_basic();
    t_widths();
    t_output();
    t_od();
    t_input();
    t_timed();
    t_clk();
    stop_test();
  end
  // All tests need well under a thousand cycles
  initial begin
    repeat (4000) @(posedge mclk);
    n_mismatch++;
    stop_test();
  end
endmodule : timed_port_tb
`default_nettype wire
